// [hdl/adc_output_flag_inhibit.sv]
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// output side of the flash converter: range flag, inhibit, modulation,
// two lane split with half-rate clock, apb registers and interrupt
module adc_output_flag_inhibit
  import adc_flag_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [LEVEL_W-1:0] input_level,
  input  wire logic               sample_clk_pos,
  input  wire logic               sample_clk_neg,
  input  wire logic               inhibit_pos,
  input  wire logic               inhibit_neg,
  input  wire logic               modulation_in_pos,
  input  wire logic               modulation_in_neg,
  output logic [CODE_W-1:0]       lane_a_bits_pos,
  output logic [CODE_W-1:0]       lane_a_bits_neg,
  output logic                    lane_a_range_flag_pos,
  output logic                    lane_a_range_flag_neg,
  output logic [CODE_W-1:0]       lane_b_bits_pos,
  output logic [CODE_W-1:0]       lane_b_bits_neg,
  output logic                    lane_b_range_flag_pos,
  output logic                    lane_b_range_flag_neg,
  output logic                    half_rate_out_clk_pos,
  output logic                    half_rate_out_clk_neg,
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [LEVEL_W-1:0] s_level;
  logic [5:0]         s_ctl;
  logic               s_clk;
  logic               s_inhibit;
  logic               s_mod_high;

  // the level bus is only used at a sample edge, long after it settled
  sync_two_stage #(.W(LEVEL_W)) u_sync_level (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (input_level),
    .sync_out (s_level)
  );

  sync_two_stage #(.W(6)) u_sync_ctl (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sample_clk_pos, sample_clk_neg,
                inhibit_pos, inhibit_neg,
                modulation_in_pos, modulation_in_neg}),
    .sync_out (s_ctl)
  );

  // differential pairs resolved after the second stage
  assign s_clk      = s_ctl[5] & ~s_ctl[4];
  assign s_inhibit  = s_ctl[3] & ~s_ctl[2];     // RULE_03
  assign s_mod_high = s_ctl[1] & ~s_ctl[0];     // RULE_08

  ////////////////////////////////////////////////////////////////////////////
  // sample clock edge detection

  logic clk_d;
  logic clk_rise;
  logic clk_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= s_clk;
    end
  end

  assign clk_rise = s_clk & ~clk_d;
  assign clk_fall = ~s_clk & clk_d;

  ////////////////////////////////////////////////////////////////////////////
  // registers written by software

  logic               ctrl_en;
  logic [LEVEL_W-1:0] ladder_top;
  logic [LEVEL_W-1:0] ladder_bot;
  logic [EV_W-1:0]    int_en;
  logic               wr_stb;
  logic               setup;
  logic               mapped;

  // a write lands at the edge that samples pready high
  assign wr_stb = psel & penable & pready & pwrite;
  assign setup  = psel & ~penable;

  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_LADDER, OFS_STATUS, OFS_INT_STAT,
      OFS_INT_EN, OFS_INT_CLR, OFS_SAMPLE_CNT: mapped = 1'b1;
      default:                                 mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en    <= CTRL_EN_RST;
      ladder_top <= LADDER_TOP_RST;
      ladder_bot <= LADDER_BOT_RST;
      int_en     <= INT_EN_RST;
    end else if (wr_stb) begin
      case (paddr)
        OFS_CTRL: begin
          ctrl_en <= pwdata[CTRL_EN_BIT];
        end
        OFS_LADDER: begin
          ladder_top <= pwdata[LADDER_TOP_LSB +: LEVEL_W];
          ladder_bot <= pwdata[LADDER_BOT_LSB +: LEVEL_W];
        end
        OFS_INT_EN: begin
          int_en <= pwdata[EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion core: quantise, flag, force zeros, modulate

  logic                over;
  logic                under;
  logic [CODE_W-1:0]   code;
  logic [WORD_W-1:0]   core_word;
  logic [WORD_W-1:0]   mod_word;

  level_quantizer u_quant (
    .level  (s_level),
    .top    (ladder_top),
    .bottom (ladder_bot),
    .over   (over),
    .under  (under),
    .code   (code)
  );

  // flag follows each sample on its own, so it drops with in-range data
  always_comb begin
    core_word = {over | under, code};           // RULE_01 RULE_02 RULE_09
    if (s_inhibit) begin
      core_word = '0;                           // RULE_03
    end
    // modulation acts on the already forced word, ahead of the split
    mod_word = s_mod_high ? core_word : ~core_word; // RULE_04 RULE_08
  end

  ////////////////////////////////////////////////////////////////////////////
  // latency pipeline: capture on a rise, hold one cycle, launch on a fall

  logic [WORD_W-1:0] stage1;
  logic [WORD_W-1:0] stage2;
  logic              valid1;
  logic              valid2;
  logic [31:0]       sample_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
      valid1 <= 1'b0;
      valid2 <= 1'b0;
    end else if (clk_rise) begin
      stage1 <= mod_word;
      valid1 <= ctrl_en;
      stage2 <= stage1;                         // RULE_06
      valid2 <= valid1;
    end
  end

  // count of converted samples, visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt <= '0;
    end else if (clk_rise && ctrl_en) begin
      sample_cnt <= sample_cnt + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two lane split and half-rate clock

  lane_t next_lane;
  logic  out_clk;

  // a new clock level of one is a rising edge, so lane a is due
  assign next_lane = out_clk ? LANE_B : LANE_A;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_clk               <= 1'b0;
      half_rate_out_clk_pos <= 1'b0;
      half_rate_out_clk_neg <= 1'b1;
    end else if (clk_fall && valid2) begin
      out_clk               <= ~out_clk;        // RULE_10
      half_rate_out_clk_pos <= ~out_clk;
      half_rate_out_clk_neg <= out_clk;
    end
  end

  // lanes and clock move in the same pclk cycle, keeping phase fixed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_a_bits_pos       <= '0;
      lane_a_bits_neg       <= '1;
      lane_a_range_flag_pos <= 1'b0;
      lane_a_range_flag_neg <= 1'b1;
      lane_b_bits_pos       <= '0;
      lane_b_bits_neg       <= '1;
      lane_b_range_flag_pos <= 1'b0;
      lane_b_range_flag_neg <= 1'b1;
    end else if (clk_fall && valid2) begin
      case (next_lane)
        LANE_A: begin                           // RULE_07 RULE_10
          lane_a_bits_pos       <= stage2[CODE_W-1:0];
          lane_a_bits_neg       <= ~stage2[CODE_W-1:0];
          lane_a_range_flag_pos <= stage2[CODE_W];
          lane_a_range_flag_neg <= ~stage2[CODE_W];
        end
        LANE_B: begin                           // RULE_07 RULE_10
          lane_b_bits_pos       <= stage2[CODE_W-1:0];
          lane_b_bits_neg       <= ~stage2[CODE_W-1:0];
          lane_b_range_flag_pos <= stage2[CODE_W];
          lane_b_range_flag_neg <= ~stage2[CODE_W];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, sticky; a new event beats a clear in the same cycle

  logic [EV_W-1:0] int_stat;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clr_mask;
  logic [EV_W-1:0] next_int_stat;
  logic            inhibit_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_d <= 1'b0;
    end else begin
      inhibit_d <= s_inhibit;
    end
  end

  always_comb begin
    events              = '0;
    events[EV_OVER]     = clk_rise & ctrl_en & over;
    events[EV_UNDER]    = clk_rise & ctrl_en & under;
    events[EV_INHIBIT]  = s_inhibit & ~inhibit_d;
    clr_mask            = '0;
    if (wr_stb && paddr == OFS_INT_CLR) begin
      clr_mask = pwdata[EV_W-1:0];
    end
    next_int_stat = (int_stat & ~clr_mask) | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
      irq      <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq      <= |(next_int_stat & int_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read side: data prepared in setup, answered in the first access

  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    case (paddr)
      OFS_CTRL: begin
        rd_val[CTRL_EN_BIT] = ctrl_en;
      end
      OFS_LADDER: begin
        rd_val[LADDER_TOP_LSB +: LEVEL_W] = ladder_top;
        rd_val[LADDER_BOT_LSB +: LEVEL_W] = ladder_bot;
      end
      OFS_STATUS: begin
        rd_val[ST_INHIBIT]               = s_inhibit;
        rd_val[ST_MOD_HIGH]              = s_mod_high;
        rd_val[ST_OUT_CLK]               = out_clk;
        rd_val[ST_FLAG]                  = stage2[CODE_W];
        rd_val[ST_BITS_LSB +: CODE_W]    = stage2[CODE_W-1:0];
      end
      OFS_INT_STAT: begin
        rd_val[EV_W-1:0] = int_stat;
      end
      OFS_INT_EN: begin
        rd_val[EV_W-1:0] = int_en;
      end
      OFS_SAMPLE_CNT: begin
        rd_val = sample_cnt;
      end
      default: begin
        rd_val = '0;                            // clear register reads zero
      end
    endcase
  end

  // one fixed wait-free access: pready rises for exactly the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : rd_val;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : adc_output_flag_inhibit

// [hdl/level_quantizer.sv]
`timescale 1ns/1ps
// flash style compare of one level against seven ladder taps
module level_quantizer
  import adc_flag_pkg::*;
(
  input  wire logic [LEVEL_W-1:0] level,
  input  wire logic [LEVEL_W-1:0] top,
  input  wire logic [LEVEL_W-1:0] bottom,
  output logic                    over,
  output logic                    under,
  output logic [CODE_W-1:0]       code
);

  logic [LEVEL_W-1:0] span;
  logic [LEVEL_W-1:0] thr [1:7];

  assign span = top - bottom;

  // taps spaced evenly between the two ladder ends
  for (genvar k = 1; k < 8; k++) begin : g_tap
    logic [10:0] prod;
    assign prod   = 11'(span) * 11'(k);
    assign thr[k] = bottom + prod[10:3];
  end

  assign over  = (level > top);                 // RULE_01
  assign under = (level < bottom);              // RULE_01

  // count taps at or below the level; clipped at both ends
  always_comb begin
    code = CODE_BOT;
    for (int k = 1; k < 8; k++) begin
      if (level >= thr[k]) begin
        code = code + 3'd1;
      end
    end
    if (over) begin
      code = CODE_TOP;                          // RULE_09
    end
    if (under) begin
      code = CODE_BOT;                          // RULE_09
    end
  end

endmodule : level_quantizer

// [hdl/sync_two_stage.sv]
`timescale 1ns/1ps
// two flop synchroniser; only the second stage is visible outside
module sync_two_stage #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sync_two_stage

// [shared/adc_flag_pkg.sv]
// Function
// (RULE_01) range flag high when input is above top tap or below bottom tap
// (RULE_02) range flag clears on the next sample that lies in range
// (RULE_03) while inhibit is asserted every converted data bit is zero
// (RULE_04) zero forcing happens before modulation and before the lane split
// (RULE_05) receiver keeps inhibit released while real sample data is needed
// (RULE_06) each sample reaches a lane 1.5 sample clock cycles after capture
// (RULE_07) lane a changes on rising, lane b on falling half-rate clock edge
// (RULE_08) all outputs are inverted while modulation input is low; the code inverts lane bits and range flags, not the half-rate clock
// (RULE_09) bottom of ten levels is flag with zero bits, top is all ones
// (RULE_10) successive samples alternate between lane a and lane b
package adc_flag_pkg;

  localparam int LEVEL_W = 8;
  localparam int CODE_W  = 3;
  localparam int ADDR_W  = 8;
  localparam int EV_W    = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LADDER     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_INT_EN     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT_CLR    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_CNT = 8'h18;

  // field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int LADDER_TOP_LSB = 8;
  localparam int LADDER_BOT_LSB = 0;
  localparam int EV_OVER        = 0;
  localparam int EV_UNDER       = 1;
  localparam int EV_INHIBIT     = 2;
  localparam int ST_INHIBIT     = 0;
  localparam int ST_MOD_HIGH    = 1;
  localparam int ST_OUT_CLK     = 2;
  localparam int ST_FLAG        = 3;
  localparam int ST_BITS_LSB    = 4;

  // values after reset
  localparam logic              CTRL_EN_RST    = 1'b1;
  localparam logic [LEVEL_W-1:0] LADDER_TOP_RST = 8'hc0;
  localparam logic [LEVEL_W-1:0] LADDER_BOT_RST = 8'h40;
  localparam logic [EV_W-1:0]   INT_EN_RST     = 3'h0;

  // code word carried through the output path: {flag, bits}
  localparam int WORD_W = CODE_W + 1;
  localparam logic [CODE_W-1:0] CODE_TOP = 3'h7;
  localparam logic [CODE_W-1:0] CODE_BOT = 3'h0;

  typedef enum logic {LANE_A, LANE_B} lane_t;

endpackage : adc_flag_pkg

// [tb/adc_flag_asserts.sv]
`timescale 1ns/1ps
module adc_flag_asserts
  import adc_flag_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              inhibit_pos,
  input wire logic              inhibit_neg,
  input wire logic              modulation_in_pos,
  input wire logic              modulation_in_neg,
  input wire logic [CODE_W-1:0] lane_a_bits_pos,
  input wire logic              lane_a_range_flag_pos,
  input wire logic [CODE_W-1:0] lane_b_bits_pos,
  input wire logic              lane_b_range_flag_pos,
  input wire logic              half_rate_out_clk_pos,
  input wire logic [CODE_W-1:0] lane_a_bits_neg,
  input wire logic              lane_a_range_flag_neg,
  input wire logic [CODE_W-1:0] lane_b_bits_neg,
  input wire logic              lane_b_range_flag_neg,
  input wire logic              half_rate_out_clk_neg
);
  logic [5:0] inh_cnt;
  logic [5:0] mhi_cnt;
  logic [5:0] mlo_cnt;
  logic       inh;
  logic       mhi;

  assign inh = inhibit_pos & ~inhibit_neg;
  assign mhi = modulation_in_pos & ~modulation_in_neg;

  function automatic logic [5:0] bump(input logic [5:0] c, input logic on);
    if (!on) return 6'h00;
    return (c == 6'h3f) ? c : c + 6'h01;
  endfunction : bump

  // hold counters: pins cross sync flops and the sample pipeline, so only
  // levels held this long tell what a launched word must carry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inh_cnt <= 6'h00;
      mhi_cnt <= 6'h00;
      mlo_cnt <= 6'h00;
    end else begin
      inh_cnt <= bump(inh_cnt, inh);
      mhi_cnt <= bump(mhi_cnt, mhi);
      mlo_cnt <= bump(mlo_cnt, !mhi);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_setup; psel && !penable; endsequence
  sequence clk_rise; $rose(half_rate_out_clk_pos); endsequence
  sequence clk_fall; $fell(half_rate_out_clk_pos); endsequence

  ready_next_a: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without access");
  lane_a_edge_a: assert property (
    $changed({lane_a_bits_pos, lane_a_range_flag_pos}) |-> clk_rise)
    else $error("lane a moved off rising edge");
  lane_b_edge_a: assert property (
    $changed({lane_b_bits_pos, lane_b_range_flag_pos}) |-> clk_fall)
    else $error("lane b moved off falling edge");
  toggle_gap_a: assert property (
    $changed(half_rate_out_clk_pos) |=> $stable(half_rate_out_clk_pos)[*8])
    else $error("half rate clock toggled too soon");
  inhibit_zero_a: assert property (
    clk_rise ##0 (inh_cnt >= 6'h28 && mhi_cnt >= 6'h28)
    |-> lane_a_bits_pos == 3'h0 && !lane_a_range_flag_pos)
    else $error("inhibited word not zero");
  inhibit_inv_a: assert property (
    clk_fall ##0 (inh_cnt >= 6'h28 && mlo_cnt >= 6'h28)
    |-> lane_b_bits_pos == 3'h7 && lane_b_range_flag_pos)
    else $error("inverted zero word wrong");
  end_codes_a: assert property (
    clk_rise ##0 (inh_cnt == 6'h00 && mhi_cnt >= 6'h28 &&
                  lane_a_range_flag_pos)
    |-> lane_a_bits_pos inside {3'h0, 3'h7})
    else $error("flagged word not an end code");
  // the negative legs must mirror the positive ones at every cycle
  pair_compl_a: assert property (
    {lane_a_bits_neg, lane_a_range_flag_neg, lane_b_bits_neg,
     lane_b_range_flag_neg, half_rate_out_clk_neg} ==
    ~{lane_a_bits_pos, lane_a_range_flag_pos, lane_b_bits_pos,
      lane_b_range_flag_pos, half_rate_out_clk_pos})
    else $error("complement output differs");
endmodule : adc_flag_asserts

// [tb/rx_model.sv]
`timescale 1ns/1ps
module rx_model
  import adc_flag_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              inhibit_req,
  input  wire logic              mod_high_req,
  input  wire logic [CODE_W-1:0] lane_a_bits_pos,
  input  wire logic              lane_a_range_flag_pos,
  input  wire logic [CODE_W-1:0] lane_b_bits_pos,
  input  wire logic              lane_b_range_flag_pos,
  input  wire logic              half_rate_out_clk_pos,
  output logic                   inhibit_pos,
  output logic                   inhibit_neg,
  output logic                   modulation_in_pos,
  output logic                   modulation_in_neg,
  output logic [WORD_W-1:0]      got_a,
  output logic [WORD_W-1:0]      got_b,
  output logic [15:0]            got_cnt
);
  logic clk_seen;

  // control pairs; inhibit stays released unless the bench asks for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_pos       <= 1'b0;
      inhibit_neg       <= 1'b1;
      modulation_in_pos <= 1'b1;
      modulation_in_neg <= 1'b0;
    end else begin
      inhibit_pos       <= inhibit_req;
      inhibit_neg       <= ~inhibit_req;
      modulation_in_pos <= mod_high_req;
      modulation_in_neg <= ~mod_high_req;
    end
  end

  // lanes move with the clock, so a word is taken one cycle after the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_seen <= 1'b0;
      got_a    <= 4'h0;
      got_b    <= 4'h0;
      got_cnt  <= 16'h0000;
    end else begin
      clk_seen <= half_rate_out_clk_pos;
      if (half_rate_out_clk_pos != clk_seen) begin
        got_cnt <= got_cnt + 16'h0001;
        if (half_rate_out_clk_pos) begin
          got_a <= {lane_a_range_flag_pos, lane_a_bits_pos};
        end else begin
          got_b <= {lane_b_range_flag_pos, lane_b_bits_pos};
        end
      end
    end
  end
endmodule : rx_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
`define CHECK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  mismatches++; $display("wrong value %s expected %h seen %h", nm, ex, gt); \
  end end
module tb_top
  import adc_flag_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sclk;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic re, inhibit_req, mod_high_req, inh_p, inh_n, mod_p, mod_n, hclk;
  logic [CODE_W-1:0] a_bits, b_bits;
  logic a_flag, b_flag;
  logic [WORD_W-1:0] got_a, got_b;
  logic [15:0] got_cnt, c;
  logic [7:0] input_level, top, bot;
  logic [7:0] corner [8] = '{8'h00, 8'h3f, 8'h40, 8'h60,
                             8'hc0, 8'hc1, 8'hff, 8'h80};
  int checks, mismatches;

  adc_output_flag_inhibit DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_level(input_level), .sample_clk_pos(sclk), .sample_clk_neg(~sclk),
    .inhibit_pos(inh_p), .inhibit_neg(inh_n), .modulation_in_pos(mod_p),
    .modulation_in_neg(mod_n), .lane_a_bits_pos(a_bits), .lane_a_bits_neg(),
    .lane_a_range_flag_pos(a_flag), .lane_a_range_flag_neg(),
    .lane_b_bits_pos(b_bits), .lane_b_bits_neg(),
    .lane_b_range_flag_pos(b_flag), .lane_b_range_flag_neg(),
    .half_rate_out_clk_pos(hclk), .half_rate_out_clk_neg(), .irq(irq));
  rx_model rx (.pclk(pclk), .presetn(presetn), .inhibit_req(inhibit_req),
    .mod_high_req(mod_high_req), .lane_a_bits_pos(a_bits),
    .lane_a_range_flag_pos(a_flag), .lane_b_bits_pos(b_bits),
    .lane_b_range_flag_pos(b_flag), .half_rate_out_clk_pos(hclk),
    .inhibit_pos(inh_p), .inhibit_neg(inh_n), .modulation_in_pos(mod_p),
    .modulation_in_neg(mod_n), .got_a(got_a), .got_b(got_b), .got_cnt(got_cnt));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // sample clock phase is offset so its edges drift against pclk
  initial begin
    sclk = 1'b0;
    #3;
    forever #62.5 sclk = ~sclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_words(input int n);
    int t;
    t = 0;
    c = got_cnt;
    while (got_cnt - c < n[15:0] && t < 400) begin @(posedge pclk); t++; end
    if (t >= 400) mismatches++;
  endtask : wait_words

  function automatic logic [3:0] exp_word(input logic [7:0] lv, tp, bt);
    int n;
    n = 0;
    if (lv > tp) return 4'hf;
    if (lv < bt) return 4'h8;
    for (int i = 1; i < 8; i++) begin
      if (int'(bt) + ((int'(tp - bt) * i) >> 3) <= lv) begin
        n++;
      end
    end
    return {1'b0, n[2:0]};
  endfunction : exp_word

  task automatic lv_test(input logic [7:0] lv);
    input_level <= lv;
    wait_words(4);
    `CHECK("lane a", exp_word(lv, top, bot), got_a)
    `CHECK("lane b word", exp_word(lv, top, bot), got_b)
  endtask : lv_test

  ////////////////////////////////////////////////////////////////////////
  // the limit is far beyond the roughly 15 us the sequence needs
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(60461));
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; input_level = 8'h80;
    inhibit_req = 1'b0; mod_high_req = 1'b1; top = 8'hc0; bot = 8'h40;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(OFS_CTRL, 1'b0, 32'h0);
    `CHECK("ctrl", 32'h1, rv)
    apb(OFS_LADDER, 1'b0, 32'h0);
    `CHECK("ladder", 32'h0000c040, rv)
    apb(8'h1c, 1'b1, 32'hffffffff);
    `CHECK("unmapped err", 1'b1, re)
    for (int i = 0; i < 8; i++) lv_test(corner[i]);
    apb(OFS_INT_STAT, 1'b0, 32'h0);
    `CHECK("range events", 2'h3, rv[1:0])
    for (int i = 0; i < 12; i++) begin
      if (i % 4 == 0) begin
        top = 8'h80 | 8'($urandom());
        bot = 8'h7f & 8'($urandom());
        apb(OFS_LADDER, 1'b1, {16'h0, top, bot});
      end
      lv_test(8'($urandom()));
    end
    // inhibit with interrupt raised, masked and cleared
    apb(OFS_INT_CLR, 1'b1, 32'h7);
    apb(OFS_INT_EN, 1'b1, 32'h4);
    inhibit_req <= 1'b1;
    // long enough that the checker sees inhibited words on lane a, the only lane it checks while modulation is high
    wait_words(12);
    `CHECK("lane a inhibit", 4'h0, got_a)
    `CHECK("lane b inhibit", 4'h0, got_b)
    `CHECK("irq raised", 1'b1, irq)
    apb(OFS_INT_EN, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    `CHECK("irq masked", 1'b0, irq)
    apb(OFS_INT_EN, 1'b1, 32'h4);
    apb(OFS_INT_CLR, 1'b1, 32'h4);
    repeat (2) @(posedge pclk);
    `CHECK("irq cleared", 1'b0, irq)
    mod_high_req <= 1'b0;
    wait_words(12);
    `CHECK("inverted inhibit", 4'hf, got_a)
    apb(OFS_STATUS, 1'b0, 32'h0);
    `CHECK("status", 6'h3d, {rv[6:3], rv[1:0]})
    inhibit_req <= 1'b0;
    lv_inv: begin
      input_level <= 8'h00;
      wait_words(4);
      `CHECK("inverted under", ~exp_word(8'h00, top, bot), got_b)
    end
    mod_high_req <= 1'b1;
    // disabled conversion must launch nothing once the pipe has drained
    apb(OFS_CTRL, 1'b1, 32'h0);
    repeat (40) @(posedge pclk);
    c = got_cnt;
    repeat (60) @(posedge pclk);
    `CHECK("dropped samples", c, got_cnt)
    // every enabled capture was launched once the pipe drained
    apb(OFS_SAMPLE_CNT, 1'b0, 32'h0);
    `CHECK("sample count", {16'h0, got_cnt}, rv)
    complete_run();
  end
endmodule : tb_top

bind adc_output_flag_inhibit adc_flag_asserts u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .inhibit_pos(inhibit_pos), .inhibit_neg(inhibit_neg),
  .modulation_in_pos(modulation_in_pos),
  .modulation_in_neg(modulation_in_neg), .lane_a_bits_pos(lane_a_bits_pos),
  .lane_a_range_flag_pos(lane_a_range_flag_pos),
  .lane_b_bits_pos(lane_b_bits_pos),
  .lane_b_range_flag_pos(lane_b_range_flag_pos),
  .half_rate_out_clk_pos(half_rate_out_clk_pos),
  .lane_a_bits_neg(lane_a_bits_neg),
  .lane_a_range_flag_neg(lane_a_range_flag_neg),
  .lane_b_bits_neg(lane_b_bits_neg),
  .lane_b_range_flag_neg(lane_b_range_flag_neg),
  .half_rate_out_clk_neg(half_rate_out_clk_neg));
